/* logic/dum_map.svh */
// timing counts, field positions and reset levels of the dual modem-pin block
// assumes: included by the modem-pin design by bare name
`ifndef DUM_MAP_SVH
`define DUM_MAP_SVH

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DUM_TEST_MODE_BIT 7

// ----------------------------------------------------------------------
// character framing and sampling
// ----------------------------------------------------------------------
`define DUM_LAST_DATA_BIT 3'h7
`define DUM_OVS_LAST 4'hf
`define DUM_OVS_MID 4'h7

// ----------------------------------------------------------------------
// reset levels of the pins
// ----------------------------------------------------------------------
`define DUM_LINE_IDLE 1'b1
`define DUM_PIN_INACTIVE 1'b1

`endif

/* logic/dum_pkg.sv */
// types and shared helpers of the dual modem-pin block
// assumes: dum_map.svh sits beside it
`default_nettype none
package dum_pkg;

  typedef logic [7:0] dum_byte_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h3,
    TX_PAR   = 3'h2,
    TX_STOP  = 3'h6
  } dum_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_PAR   = 3'h2,
    RX_STOP  = 3'h6
  } dum_rx_state_t;

  // even parity bit of a character
  function automatic logic dum_parity(input dum_byte_t d);
    return ^d;
  endfunction : dum_parity

endpackage : dum_pkg
`default_nettype wire

/* logic/dum_stream_if.sv */
// valid/ready byte stream between the channel logic and its buffer
// assumes: one clock; a word moves when valid and ready are both high
`timescale 1ns/1ps
`default_nettype none
interface dum_stream_if;
  dum_pkg::dum_byte_t data;
  logic valid;
  logic ready;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : dum_stream_if
`default_nettype wire

/* logic/dum_buf2.sv */
// two-entry buffer; the head word comes straight out of a register
// assumes: srst_i synchronous active high; producer honours ready
`timescale 1ns/1ps
`default_nettype none
module dum_buf2 (
  input wire logic clk_i,
  input wire logic srst_i,
  dum_stream_if.snk in_if,
  dum_stream_if.src out_if
);
  import dum_pkg::*;

  dum_byte_t head_ff, tail_ff, nxt_head, nxt_tail;
  logic [1:0] cnt_ff, nxt_cnt;
  logic push, pop;

  assign in_if.ready = (cnt_ff != 2'h2);
  assign out_if.valid = (cnt_ff != 2'h0);
  assign out_if.data = head_ff;
  assign push = in_if.valid && in_if.ready;
  assign pop = out_if.valid && out_if.ready;

  always_comb begin
    nxt_head = head_ff;
    nxt_tail = tail_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
      if (cnt_ff == 2'h0) begin
        nxt_head = in_if.data;
      end else begin
        nxt_tail = in_if.data;
      end
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
      nxt_head = tail_ff;
    end else if (pop && push) begin
      // only possible with one word held, so the new word becomes head
      nxt_head = in_if.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      head_ff <= 8'h00;
      tail_ff <= 8'h00;
      cnt_ff <= 2'h0;
    end else begin
      head_ff <= nxt_head;
      tail_ff <= nxt_tail;
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : dum_buf2
`default_nettype wire

/* logic/dum_modem_pins.sv */
// two serial channels with their active-low modem handshake pins
// assumes: one 100 MHz clock, srst_i is the system reset, pins synchronous
`timescale 1ns/1ps
`default_nettype none
`include "dum_map.svh"
module dum_modem_pins (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0][7:0] extended_control_one_i,
  input wire logic [1:0][15:0] divisor_i,
  input wire logic [1:0] loopback_i,
  input wire logic [1:0] parity_en_i,
  input wire logic [1:0] dtr_req_i,
  input wire logic [1:0] rts_req_i,
  input wire dum_pkg::dum_byte_t [1:0] tx_data_i,
  input wire logic [1:0] tx_valid_i,
  output logic [1:0] tx_ready_o,
  output dum_pkg::dum_byte_t [1:0] rx_data_o,
  output logic [1:0] rx_valid_o,
  output logic [1:0] rx_parity_err_o,
  output logic [1:0] rx_frame_err_o,
  output logic [1:0] cts_o,
  output logic [1:0] dsr_o,
  output logic [1:0] dcd_o,
  output logic [1:0] ri_o,
  output logic [1:0] ring_wake_o,
  input wire logic [1:0] ring_wake_clr_i,
  input wire logic serial_in_one_i,
  input wire logic serial_in_two_i,
  output logic serial_out_one_o,
  output logic serial_out_two_o,
  output logic dtr_n_baud_clock_out_one_o,
  output logic dtr_n_baud_clock_out_two_o,
  output logic [1:0] rts_n_o,
  input wire logic [1:0] cts_n_i,
  input wire logic [1:0] dsr_n_i,
  input wire logic [1:0] dcd_n_i,
  input wire logic [1:0] ri_n_i
);
  import dum_pkg::*;

  logic [1:0] sin, sout, dtr_pin;

  assign sin = {serial_in_two_i, serial_in_one_i};
  assign serial_out_one_o = sout[0];
  assign serial_out_two_o = sout[1];
  assign dtr_n_baud_clock_out_one_o = dtr_pin[0];
  assign dtr_n_baud_clock_out_two_o = dtr_pin[1];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    // ------------------------------------------------------------------
    // baud generator: one tick per sixteenth of a bit
    // ------------------------------------------------------------------
    logic [15:0] div_cnt_ff, nxt_div_cnt, div_top;
    logic nxt_bout, tick;

    // a divisor of zero behaves as one rather than stalling the channel
    assign div_top = (divisor_i[c] == 16'h0000) ? 16'h0000
                                                 : divisor_i[c] - 16'h0001;
    assign tick = (div_cnt_ff >= div_top);

    always_comb begin
      nxt_div_cnt = tick ? 16'h0000 : div_cnt_ff + 16'h0001;
      nxt_bout = (nxt_div_cnt < {1'b0, divisor_i[c][15:1]});
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        div_cnt_ff <= 16'h0000;
      end else begin
        div_cnt_ff <= nxt_div_cnt;
      end
    end

    // ------------------------------------------------------------------
    // transmit buffer and shifter
    // ------------------------------------------------------------------
    dum_stream_if fill_if ();
    dum_stream_if drain_if ();

    assign fill_if.valid = tx_valid_i[c];
    assign fill_if.data = tx_data_i[c];
    assign tx_ready_o[c] = fill_if.ready;

    dum_buf2 u_buf (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .in_if(fill_if),
      .out_if(drain_if)
    );

    dum_tx_state_t tx_st_ff, nxt_tx_st;
    dum_byte_t tx_sh_ff, nxt_tx_sh;
    logic [2:0] tx_bit_ff, nxt_tx_bit;
    logic [3:0] tx_ovs_ff, nxt_tx_ovs;
    logic tx_line_ff, nxt_tx_line, tx_par_ff, nxt_tx_par, tx_end;

    // a word leaves the buffer only on a tick so the start bit is full width
    assign drain_if.ready = (tx_st_ff == TX_IDLE) && tick;
    assign tx_end = tick && (tx_ovs_ff == `DUM_OVS_LAST);

    always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_tx_bit = tx_bit_ff;
      nxt_tx_ovs = tick ? tx_ovs_ff + 4'h1 : tx_ovs_ff;
      nxt_tx_line = tx_line_ff;
      nxt_tx_par = tx_par_ff;
      case (tx_st_ff)
        TX_IDLE: begin
          nxt_tx_ovs = 4'h0;
          if (drain_if.valid && drain_if.ready) begin
            nxt_tx_st = TX_START;
            nxt_tx_sh = drain_if.data;
            nxt_tx_par = dum_parity(drain_if.data);
            nxt_tx_bit = 3'h0;
            nxt_tx_line = 1'b0;
          end
        end
        TX_START: begin
          if (tx_end) begin
            nxt_tx_st = TX_DATA;
            nxt_tx_line = tx_sh_ff[0];
          end
        end
        TX_DATA: begin
          if (tx_end) begin
            nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
            nxt_tx_bit = tx_bit_ff + 3'h1;
            if (tx_bit_ff != `DUM_LAST_DATA_BIT) begin
              nxt_tx_line = tx_sh_ff[1];
            end else if (parity_en_i[c]) begin
              nxt_tx_st = TX_PAR;
              nxt_tx_line = tx_par_ff;
            end else begin
              nxt_tx_st = TX_STOP;
              nxt_tx_line = `DUM_LINE_IDLE;
            end
          end
        end
        TX_PAR: begin
          if (tx_end) begin
            nxt_tx_st = TX_STOP;
            nxt_tx_line = `DUM_LINE_IDLE;
          end
        end
        TX_STOP: begin
          if (tx_end) begin
            nxt_tx_st = TX_IDLE;
          end
        end
        default: begin
          nxt_tx_st = TX_IDLE;
          nxt_tx_line = `DUM_LINE_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        tx_st_ff <= TX_IDLE;
        tx_sh_ff <= 8'h00;
        tx_bit_ff <= 3'h0;
        tx_ovs_ff <= 4'h0;
        tx_line_ff <= `DUM_LINE_IDLE;
        tx_par_ff <= 1'b0;
      end else begin
        tx_st_ff <= nxt_tx_st;
        tx_sh_ff <= nxt_tx_sh;
        tx_bit_ff <= nxt_tx_bit;
        tx_ovs_ff <= nxt_tx_ovs;
        tx_line_ff <= nxt_tx_line;
        tx_par_ff <= nxt_tx_par;
      end
    end

    // ------------------------------------------------------------------
    // receiver, realigned to mid-bit after the start edge
    // ------------------------------------------------------------------
    dum_rx_state_t rx_st_ff, nxt_rx_st;
    dum_byte_t rx_sh_ff, nxt_rx_sh, rx_dat_ff, nxt_rx_dat;
    logic [2:0] rx_bit_ff, nxt_rx_bit;
    logic [3:0] rx_ovs_ff, nxt_rx_ovs;
    logic rx_vld_ff, nxt_rx_vld, rx_perr_ff, nxt_rx_perr;
    logic rx_ferr_ff, nxt_rx_ferr, rx_pbad_ff, nxt_rx_pbad;
    logic rxd, rx_end;

    // loopback feeds the receiver from the shifter, not from the pin
    assign rxd = loopback_i[c] ? tx_line_ff : sin[c];
    assign rx_end = tick && (rx_ovs_ff == `DUM_OVS_LAST);

    always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_dat = rx_dat_ff;
      nxt_rx_bit = rx_bit_ff;
      nxt_rx_ovs = tick ? rx_ovs_ff + 4'h1 : rx_ovs_ff;
      nxt_rx_vld = 1'b0;
      nxt_rx_perr = rx_perr_ff;
      nxt_rx_ferr = rx_ferr_ff;
      nxt_rx_pbad = rx_pbad_ff;
      case (rx_st_ff)
        RX_IDLE: begin
          nxt_rx_ovs = 4'h0;
          if (tick && !rxd) begin
            nxt_rx_st = RX_START;
          end
        end
        RX_START: begin
          if (tick && rx_ovs_ff == `DUM_OVS_MID) begin
            // a start bit gone by mid-bit was a glitch
            nxt_rx_st = rxd ? RX_IDLE : RX_DATA;
            nxt_rx_ovs = 4'h0;
            nxt_rx_bit = 3'h0;
            nxt_rx_pbad = 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            nxt_rx_sh = {rxd, rx_sh_ff[7:1]};
            nxt_rx_bit = rx_bit_ff + 3'h1;
            if (rx_bit_ff == `DUM_LAST_DATA_BIT) begin
              nxt_rx_st = parity_en_i[c] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_end) begin
            nxt_rx_pbad = (rxd != dum_parity(rx_sh_ff));
            nxt_rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            nxt_rx_dat = rx_sh_ff;
            nxt_rx_vld = 1'b1;
            nxt_rx_perr = rx_pbad_ff;
            nxt_rx_ferr = !rxd;
            nxt_rx_st = RX_IDLE;
          end
        end
        default: begin
          nxt_rx_st = RX_IDLE;
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        rx_st_ff <= RX_IDLE;
        rx_sh_ff <= 8'h00;
        rx_dat_ff <= 8'h00;
        rx_bit_ff <= 3'h0;
        rx_ovs_ff <= 4'h0;
        rx_vld_ff <= 1'b0;
        rx_perr_ff <= 1'b0;
        rx_ferr_ff <= 1'b0;
        rx_pbad_ff <= 1'b0;
      end else begin
        rx_st_ff <= nxt_rx_st;
        rx_sh_ff <= nxt_rx_sh;
        rx_dat_ff <= nxt_rx_dat;
        rx_bit_ff <= nxt_rx_bit;
        rx_ovs_ff <= nxt_rx_ovs;
        rx_vld_ff <= nxt_rx_vld;
        rx_perr_ff <= nxt_rx_perr;
        rx_ferr_ff <= nxt_rx_ferr;
        rx_pbad_ff <= nxt_rx_pbad;
      end
    end

    assign rx_data_o[c] = rx_dat_ff;
    assign rx_valid_o[c] = rx_vld_ff;
    assign rx_parity_err_o[c] = rx_perr_ff;
    assign rx_frame_err_o[c] = rx_ferr_ff;

    // ------------------------------------------------------------------
    // modem pins, status and ring wake
    // ------------------------------------------------------------------
    logic sout_ff, nxt_sout, dtr_ff, nxt_dtr, rts_ff, nxt_rts;
    logic ri_prev_ff, nxt_ri_prev, wake_ff, nxt_wake;
    logic [3:0] msr_ff, nxt_msr;

    always_comb begin
      // loopback keeps the line idle so the partner sees nothing
      nxt_sout = loopback_i[c] ? `DUM_LINE_IDLE : tx_line_ff;
      nxt_rts = loopback_i[c] ? `DUM_PIN_INACTIVE : !rts_req_i[c];
      if (extended_control_one_i[c][`DUM_TEST_MODE_BIT]) begin
        nxt_dtr = nxt_bout;
      end else begin
        nxt_dtr = loopback_i[c] ? `DUM_PIN_INACTIVE : !dtr_req_i[c];
      end
      // order: ri, dcd, dsr, cts; loopback ties dsr and cts to the own requests, holds ri and dcd low
      if (loopback_i[c]) begin
        nxt_msr = {1'b0, 1'b0, dtr_req_i[c], rts_req_i[c]};
      end else begin
        nxt_msr = {!ri_n_i[c], !dcd_n_i[c], !dsr_n_i[c], !cts_n_i[c]};
      end
      // the ring pin is watched whatever the loopback or power state
      nxt_ri_prev = ri_n_i[c];
      nxt_wake = (ri_prev_ff && !ri_n_i[c]) ||
                 (wake_ff && !ring_wake_clr_i[c]);
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        sout_ff <= `DUM_LINE_IDLE;
        dtr_ff <= `DUM_PIN_INACTIVE;
        rts_ff <= `DUM_PIN_INACTIVE;
        msr_ff <= 4'h0;
        ri_prev_ff <= `DUM_PIN_INACTIVE;
        wake_ff <= 1'b0;
      end else begin
        sout_ff <= nxt_sout;
        dtr_ff <= nxt_dtr;
        rts_ff <= nxt_rts;
        msr_ff <= nxt_msr;
        ri_prev_ff <= nxt_ri_prev;
        wake_ff <= nxt_wake;
      end
    end

    assign sout[c] = sout_ff;
    assign dtr_pin[c] = dtr_ff;
    assign rts_n_o[c] = rts_ff;
    assign cts_o[c] = msr_ff[0];
    assign dsr_o[c] = msr_ff[1];
    assign dcd_o[c] = msr_ff[2];
    assign ri_o[c] = msr_ff[3];
    assign ring_wake_o[c] = wake_ff;
  end

endmodule : dum_modem_pins
`default_nettype wire

/* sim/dum_modem_pins_properties.sv */
// pin-level checks of the dual modem-pin block
// assumes: bound to dum_modem_pins; one clock, srst_i sync active high
`timescale 1ns/1ps
`default_nettype none
module dum_modem_pins_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [1:0][7:0] extended_control_one_i,
  input wire logic [1:0][15:0] divisor_i,
  input wire logic [1:0] loopback_i,
  input wire logic [1:0] dtr_req_i,
  input wire logic [1:0] rts_req_i,
  input wire logic [1:0] ri_n_i,
  input wire logic [1:0] ring_wake_o,
  input wire logic serial_out_one_o,
  input wire logic serial_out_two_o,
  input wire logic dtr_n_baud_clock_out_one_o,
  input wire logic dtr_n_baud_clock_out_two_o,
  input wire logic [1:0] rts_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_released;
    $fell(srst_i);
  endsequence
  // divisor 1 keeps the baud output flat, so only divisor 2 is judged
  sequence s_test_held;
    (extended_control_one_i[0][7] && divisor_i[0] == 16'h0002) [*4];
  endsequence
  property p_line_rst;
    s_released |-> serial_out_one_o && serial_out_two_o;
  endproperty
  property p_dtr_rst;
    s_released |-> dtr_n_baud_clock_out_one_o && dtr_n_baud_clock_out_two_o;
  endproperty
  property p_rts_rst;
    s_released |-> rts_n_o == 2'h3;
  endproperty
  property p_dtr_lb;
    loopback_i[0] && !extended_control_one_i[0][7]
      |=> dtr_n_baud_clock_out_one_o;
  endproperty
  property p_dtr_req;
    !loopback_i[0] && !extended_control_one_i[0][7]
      |=> dtr_n_baud_clock_out_one_o == !$past(dtr_req_i[0]);
  endproperty
  property p_rts_lb;
    loopback_i[0] |=> rts_n_o[0];
  endproperty
  property p_rts_req;
    !loopback_i[1] |=> rts_n_o[1] == !$past(rts_req_i[1]);
  endproperty
  property p_test;
    s_test_held |-> ##[1:4] $changed(dtr_n_baud_clock_out_one_o);
  endproperty
  property p_ring;
    $fell(ri_n_i[0]) |=> ring_wake_o[0];
  endproperty
  a_line_rst: assert property (p_line_rst) else $error("line not idle");
  a_dtr_rst: assert property (p_dtr_rst) else $error("dtr not high");
  a_rts_rst: assert property (p_rts_rst) else $error("rts not high");
  a_dtr_lb: assert property (p_dtr_lb) else $error("dtr in loopback");
  a_dtr_req: assert property (p_dtr_req) else $error("dtr level");
  a_rts_lb: assert property (p_rts_lb) else $error("rts in loopback");
  a_rts_req: assert property (p_rts_req) else $error("rts level");
  a_test: assert property (p_test) else $error("no baud output");
  a_ring: assert property (p_ring) else $error("ring missed");
endmodule : dum_modem_pins_properties

bind dum_modem_pins dum_modem_pins_properties dum_modem_pins_properties_inst (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .extended_control_one_i(extended_control_one_i),
  .divisor_i(divisor_i),
  .loopback_i(loopback_i),
  .dtr_req_i(dtr_req_i),
  .rts_req_i(rts_req_i),
  .ri_n_i(ri_n_i),
  .ring_wake_o(ring_wake_o),
  .serial_out_one_o(serial_out_one_o),
  .serial_out_two_o(serial_out_two_o),
  .dtr_n_baud_clock_out_one_o(dtr_n_baud_clock_out_one_o),
  .dtr_n_baud_clock_out_two_o(dtr_n_baud_clock_out_two_o),
  .rts_n_o(rts_n_o)
);
`default_nettype wire

/* sim/dum_modem_partner.sv */
// modem side: null-modem cross of the lines; status pins driven from the bench levels
// assumes: bench sets the *_on_i levels off the clock edge
`timescale 1ns/1ps
`default_nettype none
module dum_modem_partner (
  input wire logic line_one_i,
  input wire logic line_two_i,
  input wire logic [1:0] cts_on_i,
  input wire logic [1:0] dsr_on_i,
  input wire logic [1:0] dcd_on_i,
  input wire logic [1:0] ring_on_i,
  output logic line_one_o,
  output logic line_two_o,
  output logic [1:0] cts_n_o,
  output logic [1:0] dsr_n_o,
  output logic [1:0] dcd_n_o,
  output logic [1:0] ri_n_o
);
  // each channel hears the other, so both directions are exercised
  assign line_one_o = line_two_i;
  assign line_two_o = line_one_i;
  assign cts_n_o = ~cts_on_i;
  assign dsr_n_o = ~dsr_on_i;
  assign dcd_n_o = ~dcd_on_i;
  assign ri_n_o = ~ring_on_i;
endmodule : dum_modem_partner
`default_nettype wire

/* sim/test_dual_uart_modem_pin_interface.sv */
// self-checking bench of the dual modem-pin block
// assumes: design, checker and modem model compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_dual_uart_modem_pin_interface;
  import dum_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0][7:0] ext = '0;
  logic [1:0][15:0] div = {16'h0001, 16'h0001};
  logic [1:0] lb = '0, par = '0, dtr_rq = '0, rts_rq = '0, tx_valid = '0;
  logic [1:0] clr = '0, cts_on = '0, dsr_on = '0, dcd_on = '0, ri_on = '0;
  dum_byte_t [1:0] tx_data = '0;
  dum_byte_t [1:0] rx_data;
  logic [1:0] tx_ready, rx_valid, perr, ferr, cts, dsr, dcd, ri, wake, rts_n;
  logic [1:0] cts_n, dsr_n, dcd_n, ri_n;
  logic in_one, in_two, out_one, out_two, dtr_one, dtr_two;
  int fails = 0, n_tests = 0, cyc = 0;

  always #5 clk_i = ~clk_i;

  dum_modem_pins dum_modem_pins_inst (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .extended_control_one_i(ext),
    .divisor_i(div),
    .loopback_i(lb),
    .parity_en_i(par),
    .dtr_req_i(dtr_rq),
    .rts_req_i(rts_rq),
    .tx_data_i(tx_data),
    .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready),
    .rx_data_o(rx_data),
    .rx_valid_o(rx_valid),
    .rx_parity_err_o(perr),
    .rx_frame_err_o(ferr),
    .cts_o(cts),
    .dsr_o(dsr),
    .dcd_o(dcd),
    .ri_o(ri),
    .ring_wake_o(wake),
    .ring_wake_clr_i(clr),
    .serial_in_one_i(in_one),
    .serial_in_two_i(in_two),
    .serial_out_one_o(out_one),
    .serial_out_two_o(out_two),
    .dtr_n_baud_clock_out_one_o(dtr_one),
    .dtr_n_baud_clock_out_two_o(dtr_two),
    .rts_n_o(rts_n),
    .cts_n_i(cts_n),
    .dsr_n_i(dsr_n),
    .dcd_n_i(dcd_n),
    .ri_n_i(ri_n)
  );

  dum_modem_partner dum_modem_partner_inst (
    .line_one_i(out_one),
    .line_two_i(out_two),
    .cts_on_i(cts_on),
    .dsr_on_i(dsr_on),
    .dcd_on_i(dcd_on),
    .ring_on_i(ri_on),
    .line_one_o(in_one),
    .line_two_o(in_two),
    .cts_n_o(cts_n),
    .dsr_n_o(dsr_n),
    .dcd_n_o(dcd_n),
    .ri_n_o(ri_n)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // valid stays up on return so back-to-back words need no gap
  task automatic push(input int ch, input dum_byte_t b);
    int n;
    n = 0;
    tx_data[ch] = b;
    tx_valid[ch] = 1'b1;
    while (tx_ready[ch] !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk(tx_ready[ch], 1'b1);
    @(negedge clk_i);
  endtask : push

  // err is {parity error, frame error} of the character
  task automatic get_rx_err(input int ch, input dum_byte_t b,
                            input logic [1:0] err);
    int n;
    n = 0;
    while (rx_valid[ch] !== 1'b1 && n < 600) begin
      @(negedge clk_i);
      n++;
    end
    chk(rx_valid[ch], 1'b1);
    chk({perr[ch], ferr[ch], rx_data[ch]}, {err, b});
    @(negedge clk_i);
  endtask : get_rx_err

  task automatic get_rx(input int ch, input dum_byte_t b);
    get_rx_err(ch, b, 2'b00);
  endtask : get_rx

  task automatic t_pins();
    dtr_rq = 2'b11;
    rts_rq = 2'b01;
    repeat (2) @(negedge clk_i);
    chk({dtr_one, dtr_two, rts_n}, 4'h2);
    lb = 2'b01;
    repeat (2) @(negedge clk_i);
    chk({dtr_one, dtr_two, rts_n}, 4'hb);
    chk({cts, dsr, dcd, ri}, 8'h50);
    srst_i = 1'b1;
    @(negedge clk_i);
    chk({out_one, out_two, dtr_one, dtr_two, rts_n}, 6'h3f);
    srst_i = 1'b0;
    lb = 2'b00;
    dtr_rq = 2'b00;
    rts_rq = 2'b00;
    @(negedge clk_i);
  endtask : t_pins

  task automatic t_modem_in();
    cts_on = 2'b01;
    dsr_on = 2'b10;
    dcd_on = 2'b11;
    repeat (2) @(negedge clk_i);
    chk({cts, dsr, dcd, ri}, 8'h6c);
    // a clear in the cycle of a new ring edge must lose
    ri_on = 2'b11;
    clr = 2'b01;
    @(negedge clk_i);
    clr = 2'b00;
    @(negedge clk_i);
    chk({ri, wake}, 4'hf);
    clr = 2'b11;
    @(negedge clk_i);
    clr = 2'b00;
    ri_on = 2'b00;
    @(negedge clk_i);
    chk(wake, 2'b00);
  endtask : t_modem_in

  task automatic t_test_mode();
    logic hi, lo;
    hi = 1'b0;
    lo = 1'b0;
    div[0] = 16'h0002;
    ext[0] = 8'h80;
    repeat (12) begin
      @(negedge clk_i);
      if (dtr_one === 1'b1) hi = 1'b1;
      if (dtr_one === 1'b0) lo = 1'b1;
    end
    chk({hi, lo, dtr_two}, 3'h7);
    ext[0] = 8'h40;
    repeat (3) @(negedge clk_i);
    lo = 1'b0;
    repeat (8) begin
      @(negedge clk_i);
      if (dtr_one !== 1'b1) lo = 1'b1;
    end
    chk(lo, 1'b0);
    ext[0] = 8'h00;
    div[0] = 16'h0001;
  endtask : t_test_mode

  task automatic t_frame();
    logic [10:0] f;
    int n;
    f = {1'b1, ^8'ha5, 8'ha5, 1'b0};
    n = 0;
    par = 2'b11;
    push(0, 8'ha5);
    tx_valid[0] = 1'b0;
    while (out_one !== 1'b0 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < 11; i++) begin
      chk(out_one, f[i]);
      if (i < 10) repeat (16) @(negedge clk_i);
    end
    get_rx(1, 8'ha5);
    par = 2'b00;
    push(1, 8'h3c);
    tx_valid[1] = 1'b0;
    get_rx(0, 8'h3c);
  endtask : t_frame

  // loopback: the own receiver hears the word, the pin stays idle
  task automatic t_loop();
    lb = 2'b01;
    par = 2'b00;
    push(0, 8'h5a);
    tx_valid[0] = 1'b0;
    repeat (8) @(negedge clk_i);
    chk(out_one, 1'b1);
    get_rx(0, 8'h5a);
    lb = 2'b00;
  endtask : t_loop

  // a parity slot read as stop, then a stop read as parity
  task automatic t_errors();
    par = 2'b01;
    push(0, 8'h96);
    tx_valid[0] = 1'b0;
    get_rx_err(1, 8'h96, 2'b01);
    par = 2'b10;
    push(0, 8'h96);
    tx_valid[0] = 1'b0;
    get_rx_err(1, 8'h96, 2'b10);
  endtask : t_errors

  // three words fill shifter and buffer; a fourth must wait
  task automatic t_buffer();
    par = 2'b11;
    push(0, 8'h11);
    push(0, 8'h22);
    push(0, 8'h33);
    tx_data[0] = 8'h44;
    repeat (2) @(negedge clk_i);
    chk(tx_ready[0], 1'b0);
    tx_valid[0] = 1'b0;
    get_rx(1, 8'h11);
    get_rx(1, 8'h22);
    get_rx(1, 8'h33);
    chk(tx_ready[0], 1'b1);
  endtask : t_buffer

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    @(negedge clk_i);
    chk({out_one, out_two, dtr_one, dtr_two, rts_n}, 6'h3f);
    t_pins();
    t_modem_in();
    t_test_mode();
    t_frame();
    t_loop();
    t_errors();
    t_buffer();
    end_of_test();
  end

  // whole run needs about 1400 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      end_of_test();
    end
  end
endmodule : test_dual_uart_modem_pin_interface
`default_nettype wire
